/* rtl/bsp_regs.svh */
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH
// Purpose: constants of the bit-serial memory port host
// Assumes: 40 MHz sys_clk
// Notes:   strobe phase lengths in clock cycles
`define BSP_ADDR_BITS   16
`define BSP_BYTE_BITS   8
`define BSP_PAGE_BYTES  6'h20
`define BSP_SETUP_CYC   4'h2
`define BSP_STROBE_CYC  4'h3
`define BSP_HOLD_CYC    4'h2
`define BSP_SAMPLE_CYC  4'h2
`endif

/* rtl/bsp_pkg.sv */
// Purpose: types of the bit-serial memory port host
// Assumes: nothing
// Notes:   command kinds and their codes
package bsp_pkg;
  typedef enum logic [1:0] {
    BSP_CMD_READ  = 2'h0,
    BSP_CMD_WRITE = 2'h1,
    BSP_CMD_POLL  = 2'h2
  } bsp_cmd_e;
endpackage

/* rtl/bsp_buf_if.sv */
// Purpose: valid/ready word link between host and its output buffer
// Assumes: one clock
// Notes:   8-bit data words
interface bsp_buf_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* rtl/bsp_skid_buf.sv */
// Purpose: two-entry buffer for read data
// Assumes: one clock, reset_n asynchronous
// Notes:   ready falls only when both entries hold data
module bsp_skid_buf (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  bsp_buf_if.snk          in_if,
  output      logic       out_valid,
  output      logic [7:0] out_data,
  input  wire logic       out_ready
);
  logic [7:0] mem_r [2];
  logic [7:0] mem_nxt [2];
  logic       rp_r, rp_nxt, wp_r, wp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       push, pop;
  logic       vld_r, vld_nxt;
  logic [7:0] dout_r, dout_nxt;

  assign in_if.ready = (cnt_r != 2'h2);
  assign out_valid   = vld_r;
  assign out_data    = dout_r;

  always_comb begin
    push    = in_if.valid && in_if.ready;
    pop     = out_valid && out_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r] = in_if.data;
    end
    wp_nxt  = push ? ~wp_r : wp_r;
    rp_nxt  = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    vld_nxt  = (cnt_nxt != 2'h0);
    dout_nxt = mem_nxt[rp_nxt];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      rp_r     <= 1'b0;
      wp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      vld_r    <= 1'b0;
      dout_r   <= 8'h00;
    end else begin
      vld_r  <= vld_nxt;
      dout_r <= dout_nxt;
      mem_r <= mem_nxt;
      rp_r  <= rp_nxt;
      wp_r  <= wp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* rtl/bsp_host.sv */
// Purpose: host sequencer driving a bit-serial memory over bus strobes
// Assumes: 40 MHz sys_clk, pin inputs synchronous
// Notes:   one command at a time; read bytes leave through a buffer
// Function
// R1: chip select high deselects device
// R2: device drives data only when selected
// R3: data latched at first rising strobe
// R4: never write and output enable together
// R5: read sends 16 address bits msb first
// R6: eight read cycles return one byte
// R7: writing one ends sequential read
// R8: address advances and wraps after byte
// R9: read, write zero, read resets device
// R10: reset acts after zero write completes
// R11: reads after reset return high
// R12: every sequence starts with a reset; the host skips the reset for poll commands
// R13: write: reset, address, bytes, start
// R14: start is read, write one, read
// R15: page of 32 bytes wraps
// R16: partial sequence starts no write
// R17: latch clears after write or error
// R18: write protect low refuses writes
// R19: poll reads low while writing
// R20: illegal sequence drops device idle
// R21: latch held clear while protected
// R22: data bytes travel msb first
module bsp_host (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       cmd_valid,
  output      logic       cmd_ready,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [5:0] cmd_len,
  input  wire logic       wr_valid,
  output      logic       wr_ready,
  input  wire logic [7:0] wr_data,
  output      logic       rd_valid,
  input  wire logic       rd_ready,
  output      logic [7:0] rd_data,
  output      logic       busy,
  output      logic       nv_busy,
  output      logic       mem_cs_n,
  output      logic       mem_oe_n,
  output      logic       mem_we_n,
  output      logic       mem_io_o,
  output      logic       mem_io_oe,
  input  wire logic       mem_io_i
);
`include "bsp_regs.svh"

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_STRB  = 7'h04,
    ST_HOLD  = 7'h08,
    ST_NEXT  = 7'h10,
    ST_PUSH  = 7'h20,
    ST_DONE  = 7'h40
  } bsp_st_e;

  // step codes of a cycle script
  typedef enum logic [2:0] {
    PH_RST  = 3'h0,
    PH_ADDR = 3'h1,
    PH_DATA = 3'h2,
    PH_RDAT = 3'h3,
    PH_STRT = 3'h4,
    PH_END  = 3'h5,
    PH_POLL = 3'h6
  } bsp_ph_e;

  bsp_st_e          st_r, st_nxt;
  bsp_ph_e          ph_r, ph_nxt;
  bsp_pkg::bsp_cmd_e kind_r, kind_nxt;
  logic [3:0]       tmr_r, tmr_nxt;
  logic [4:0]       bit_r, bit_nxt;
  logic [5:0]       len_r, len_nxt;
  logic [15:0]      sh_r, sh_nxt;
  logic [7:0]       rx_r, rx_nxt;
  logic             rdcyc_r, rdcyc_nxt;
  logic             wbit_r, wbit_nxt;
  logic             cs_r, cs_nxt, oe_r, oe_nxt, we_r, we_nxt, iooe_r, iooe_nxt;
  logic             nvb_r, nvb_nxt;
  logic             rdy_r, rdy_nxt, wrdy_r, wrdy_nxt, busy_r, busy_nxt;
  bsp_buf_if        rbuf ();

  bsp_skid_buf u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_if     (rbuf.snk),
    .out_valid (rd_valid),
    .out_data  (rd_data),
    .out_ready (rd_ready)
  );

  assign rbuf.data = rx_r;
  assign rbuf.valid = (st_r == ST_PUSH) && (ph_r != PH_DATA);
  assign cmd_ready = rdy_r;
  assign wr_ready  = wrdy_r;
  assign busy      = busy_r;
  assign nv_busy   = nvb_r;
  assign mem_cs_n  = cs_r;
  assign mem_oe_n  = oe_r;
  assign mem_we_n  = we_r;
  assign mem_io_o  = wbit_r;
  assign mem_io_oe = iooe_r;

  // cycle kind and bit of reset/start scripts: step 0 read, 1 write, 2 read
  function automatic logic is_read(input logic [4:0] step);
    is_read = (step != 5'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r; ph_nxt = ph_r; kind_nxt = kind_r; tmr_nxt = tmr_r;
    bit_nxt = bit_r; len_nxt = len_r; sh_nxt = sh_r; rx_nxt = rx_r;
    rdcyc_nxt = rdcyc_r; wbit_nxt = wbit_r; cs_nxt = cs_r; oe_nxt = oe_r;
    we_nxt = we_r; iooe_nxt = iooe_r; nvb_nxt = nvb_r; rdy_nxt = rdy_r;
    wrdy_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (cmd_valid && rdy_r) begin
          rdy_nxt  = 1'b0;
          kind_nxt = bsp_pkg::bsp_cmd_e'(cmd_kind);
          sh_nxt   = cmd_addr;
          len_nxt  = (cmd_len == 6'h00) ? 6'h01 :
                     (cmd_len > `BSP_PAGE_BYTES) ? `BSP_PAGE_BYTES : cmd_len;
          bit_nxt  = 5'h0;
          // R12: reset leads every read and write sequence; poll skips it
          ph_nxt   = (bsp_pkg::bsp_cmd_e'(cmd_kind) == bsp_pkg::BSP_CMD_POLL) ? PH_POLL
                                                                             : PH_RST;
          st_nxt   = ST_NEXT;
        end
      end
      ST_NEXT: begin
        // choose the next bus cycle of the script
        st_nxt = ST_SETUP;
        tmr_nxt = `BSP_SETUP_CYC;
        case (ph_r)
          // R9: read, write zero, read
          PH_RST: begin
            rdcyc_nxt = is_read(bit_r);
            wbit_nxt  = 1'b0;
          end
          // R5: address msb first
          PH_ADDR: begin
            rdcyc_nxt = 1'b0;
            wbit_nxt  = sh_r[15];
          end
          // R22: data msb first
          PH_DATA: begin
            rdcyc_nxt = 1'b0;
            wbit_nxt  = sh_r[15];
          end
          // R6: eight read cycles
          PH_RDAT: rdcyc_nxt = 1'b1;
          // R14: read, write one, read
          PH_STRT: begin
            rdcyc_nxt = is_read(bit_r);
            wbit_nxt  = 1'b1;
          end
          // R7: a one ends sequential read
          PH_END: begin
            rdcyc_nxt = 1'b0;
            wbit_nxt  = 1'b1;
          end
          // R19: poll is a single read
          default: rdcyc_nxt = 1'b1;
        endcase
      end
      ST_SETUP: begin
        // R1: select only inside a cycle
        cs_nxt = 1'b0;
        // R2: io released before read
        iooe_nxt = ~rdcyc_r;
        tmr_nxt = tmr_r - 4'h1;
        if (tmr_r == 4'h1) begin
          // R4: only one strobe low
          oe_nxt  = ~rdcyc_r;
          we_nxt  = rdcyc_r;
          tmr_nxt = rdcyc_r ? `BSP_STROBE_CYC + `BSP_SAMPLE_CYC : `BSP_STROBE_CYC;
          st_nxt  = ST_STRB;
        end
      end
      ST_STRB: begin
        tmr_nxt = tmr_r - 4'h1;
        if (tmr_r == 4'h1) begin
          if (rdcyc_r) begin
            rx_nxt = {rx_r[6:0], mem_io_i};
          end
          // R3: strobe rises before chip select
          oe_nxt  = 1'b1;
          we_nxt  = 1'b1;
          tmr_nxt = `BSP_HOLD_CYC;
          st_nxt  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        tmr_nxt = tmr_r - 4'h1;
        if (tmr_r == 4'h1) begin
          cs_nxt   = 1'b1;
          iooe_nxt = 1'b0;
          st_nxt   = ST_NEXT;
          bit_nxt  = bit_r + 5'h1;
          case (ph_r)
            PH_RST: if (bit_r == 5'h2) begin
              // R10: device reset after zero write
              bit_nxt = 5'h0;
              ph_nxt  = (kind_r == bsp_pkg::BSP_CMD_READ) ? PH_ADDR : PH_ADDR;
            end
            PH_ADDR: begin
              sh_nxt = {sh_r[14:0], 1'b0};
              if (bit_r == 5'(`BSP_ADDR_BITS - 1)) begin
                bit_nxt = 5'h0;
                if (kind_r == bsp_pkg::BSP_CMD_READ) begin
                  ph_nxt = PH_RDAT;
                end else begin
                  ph_nxt = PH_DATA;
                  st_nxt = ST_PUSH;
                end
              end
            end
            PH_DATA: begin
              sh_nxt = {sh_r[14:0], 1'b0};
              if (bit_r == 5'(`BSP_BYTE_BITS - 1)) begin
                bit_nxt = 5'h0;
                len_nxt = len_r - 6'h1;
                // R13: whole bytes, then start
                // R15: length capped at one page
                // R16: start only after full load
                if (len_r == 6'h1) begin
                  ph_nxt = PH_STRT;
                end else begin
                  st_nxt = ST_PUSH;
                end
              end
            end
            PH_RDAT: if (bit_r == 5'(`BSP_BYTE_BITS - 1)) begin
              // R8: device advances address per byte
              bit_nxt = 5'h0;
              st_nxt  = ST_PUSH;
            end
            PH_STRT: if (bit_r == 5'h2) begin
              // R17: device clears latch itself
              nvb_nxt = 1'b1;
              st_nxt  = ST_DONE;
            end
            PH_END: begin
              // R20: device now idle
              st_nxt = ST_DONE;
            end
            default: begin
              // R19: low poll only while writing; protect leaves it high
              // R21: latch state is the device's
              nvb_nxt = ~rx_r[0];
              st_nxt  = ST_DONE;
            end
          endcase
        end
      end
      ST_PUSH: begin
        if (ph_r == PH_DATA) begin
          // wait for a write byte from the user
          if (wr_valid) begin
            wrdy_nxt = 1'b1;
            sh_nxt   = {wr_data, 8'h00};
            st_nxt   = ST_NEXT;
          end
        end else if (rbuf.ready) begin
          len_nxt = len_r - 6'h1;
          // R11: reads valid only after address
          st_nxt  = ST_NEXT;
          if (len_r == 6'h1) begin
            ph_nxt = PH_END;
          end
        end
      end
      ST_DONE: begin
        rdy_nxt = 1'b1;
        st_nxt  = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    busy_nxt = ~rdy_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE; ph_r <= PH_RST; kind_r <= bsp_pkg::BSP_CMD_READ;
      tmr_r <= 4'h0; bit_r <= 5'h0; len_r <= 6'h0; sh_r <= 16'h0000;
      rx_r <= 8'h00; rdcyc_r <= 1'b0; wbit_r <= 1'b0; cs_r <= 1'b1;
      oe_r <= 1'b1; we_r <= 1'b1; iooe_r <= 1'b0; nvb_r <= 1'b0;
      rdy_r <= 1'b1; wrdy_r <= 1'b0; busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt; ph_r <= ph_nxt; kind_r <= kind_nxt; tmr_r <= tmr_nxt;
      bit_r <= bit_nxt; len_r <= len_nxt; sh_r <= sh_nxt; rx_r <= rx_nxt;
      rdcyc_r <= rdcyc_nxt; wbit_r <= wbit_nxt; cs_r <= cs_nxt; oe_r <= oe_nxt;
      we_r <= we_nxt; iooe_r <= iooe_nxt; nvb_r <= nvb_nxt; rdy_r <= rdy_nxt;
      wrdy_r <= wrdy_nxt; busy_r <= busy_nxt;
    end
  end
endmodule

/* verif/bsp_host_assertions.sv */
// Purpose: port checks of the bit-serial memory host
// Assumes: one clock, reset_n active low
// Notes:   bound to bsp_host
module bsp_host_assertions (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       cmd_ready,
  input wire logic       wr_ready,
  input wire logic       rd_valid,
  input wire logic       rd_ready,
  input wire logic [7:0] rd_data,
  input wire logic       mem_cs_n,
  input wire logic       mem_oe_n,
  input wire logic       mem_we_n,
  input wire logic       mem_io_o,
  input wire logic       mem_io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_we_oe_excl: assert property (mem_we_n || mem_oe_n) else $error("we and oe low");
  a_drive_off: assert property (!mem_oe_n |-> !mem_io_oe) else $error("io driven in read");
  a_desel_off: assert property (mem_cs_n |-> !mem_io_oe) else $error("io driven deselected");
  a_we_len: assert property ($fell(mem_we_n) |-> !mem_we_n [*3] ##1 mem_we_n)
    else $error("write strobe length");
  a_oe_len: assert property ($fell(mem_oe_n) |-> !mem_oe_n [*5] ##1 mem_oe_n)
    else $error("read strobe length");
  a_we_setup: assert property ($fell(mem_we_n) |-> !$past(mem_cs_n))
    else $error("cs setup");
  a_cs_hold: assert property ($rose(mem_we_n) |-> !mem_cs_n [*2] ##1 mem_cs_n)
    else $error("cs hold");
  a_bit_stable: assert property (!mem_we_n |-> $stable(mem_io_o)) else $error("bit moved");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read byte dropped");
  a_wr_pulse: assert property (wr_ready |=> !wr_ready) else $error("wr_ready stuck");
  a_idle_quiet: assert property (cmd_ready |-> mem_cs_n) else $error("bus busy idle");
  c_write: cover property ($rose(mem_we_n));
  c_read: cover property ($rose(mem_oe_n));
  c_stall: cover property (rd_valid && !rd_ready);
endmodule
bind bsp_host bsp_host_assertions u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .cmd_ready(cmd_ready), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .rd_data(rd_data), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
  .mem_io_o(mem_io_o), .mem_io_oe(mem_io_oe));

/* verif/bsp_mem_model.sv */
// Purpose: behavioural bit-serial memory
// Assumes: strobes from the host
// Notes:   contents start as address hash
module bsp_mem_model #(parameter int NV_NS = 3000) (
  input  wire logic cs_n,
  input  wire logic oe_n,
  input  wire logic we_n,
  input  wire logic io_in,
  input  wire logic wp_n,
  output logic      io_out,
  output logic      io_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  pbuf [0:31];
  logic [7:0]  cur;
  logic [15:0] addr;
  logic [4:0]  off;
  int          st = 0, cnt = 0, last = 0, nbits = 0;
  bit          wel = 0, wact = 0, ract = 0, val = 1;
  realtime     nv_end = 0;
  initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
  assign io_en  = !cs_n && !oe_n;
  assign io_out = io_en ? val : !val;
  always @(negedge wp_n) wel = 0;
  always @(negedge oe_n or negedge cs_n) if (!oe_n && !cs_n) begin
    ract = 1;
    if (st == 6) begin
      st  = 2;
      cnt = 0;
    end
    val = ($realtime < nv_end) ? 1'b0 : (st == 2) ? mem[addr][7-cnt] : 1'b1;
  end
  always @(posedge oe_n or posedge cs_n) if (ract) begin
    ract = 0;
    last = 1;
    if (st == 2) begin
      cnt++;
      if (cnt == 8) begin
        cnt  = 0;
        addr = addr + 16'h1;
      end
    end else if (st == 3) st = (nbits > 0 && nbits % 8 == 0) ? 4 : 0;
    else if (st == 5) begin
      if (wel && wp_n && $realtime >= nv_end) begin
        for (int i = 0; i < ((nbits >= 256) ? 32 : nbits / 8); i++) begin
          off = addr[4:0] + 5'(i);
          mem[{addr[15:5], off}] = pbuf[off];
        end
        nv_end = $realtime + NV_NS;
      end
      wel = 0;
      st  = 0;
    end else if (st == 4 || (st == 1 && cnt > 0)) st = 0;
  end
  always @(negedge we_n or negedge cs_n) if (!we_n && !cs_n) wact = 1;
  always @(posedge we_n or posedge cs_n) if (wact) begin
    wact = 0;
    if (st == 1) begin
      addr = {addr[14:0], io_in};
      cnt++;
      if (cnt == 16) st = 6;
    end else if (last == 1 && !io_in) begin
      st    = 1;
      cnt   = 0;
      nbits = 0;
      wel   = wp_n;
    end else if (last == 1) begin
      st  = (st == 4) ? 5 : 0;
      wel = wel && st == 5;
    end else if (st == 6 || st == 3) begin
      st  = 3;
      cur = {cur[6:0], io_in};
      nbits++;
      if (nbits % 8 == 0) pbuf[5'(addr[4:0] + 5'(nbits / 8 - 1))] = cur;
    end else begin
      st  = 0;
      wel = 0;
    end
    last = 2;
  end
endmodule

/* verif/tb.sv */
// Purpose: self-checking bench of bsp_host
// Assumes: model memory on the pins
// Notes:   lfsr stalls and data
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, reset_n, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid;
  logic        rd_ready, busy, nv_busy, mem_cs_n, mem_oe_n, mem_we_n, mem_io_o;
  logic        mem_io_oe, m_out, m_en, wp_n;
  logic [1:0]  cmd_kind;
  logic [15:0] cmd_addr;
  logic [5:0]  cmd_len;
  logic [7:0]  wr_data, rd_data, rnd;
  logic [7:0]  ex [int];
  logic [7:0]  wq[$], rq[$];
  int          num_errors = 0, checks_done = 0;
  wire         mem_io_i = mem_io_oe ? mem_io_o : m_out;
  bsp_host DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .nv_busy(nv_busy),
    .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_io_o(mem_io_o),
    .mem_io_oe(mem_io_oe), .mem_io_i(mem_io_i));
  bsp_mem_model u_mem (.cs_n(mem_cs_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
    .io_in(mem_io_i), .wp_n(wp_n), .io_out(m_out), .io_en(m_en));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] exp_at(input logic [15:0] a);
    return ex.exists(a) ? ex[a] : a[7:0] ^ a[15:8];
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_for(input int lim);
    int i;
    i = 0;
    while (!(cmd_ready === 1'b1 && wq.size() == 0 && rq.size() == 0) && i < lim) begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= lim) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic do_cmd(input logic [1:0] k, input logic [15:0] a, input logic [5:0] n);
    int i;
    i = 0;
    @(negedge sys_clk);
    {cmd_valid, cmd_kind, cmd_addr, cmd_len} = {1'b1, k, a, n};
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1 && i < 100) begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 100) begin
      num_errors++;
      summarize();
    end
    @(negedge sys_clk) cmd_valid = 1'b0;
    wait_for(20000);
  endtask
  task automatic run(input logic [1:0] k, input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      if (k == bsp_pkg::BSP_CMD_READ) rq.push_back(exp_at(a + 16'(i)));
      else wq.push_back(rnd);
      if (k == bsp_pkg::BSP_CMD_WRITE && wp_n) ex[{a[15:5], 5'(a[4:0] + 5'(i))}] = rnd;
    end
    do_cmd(k, a, 6'(n));
  endtask
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    rnd      = lfsr(rnd);
    rd_ready = rnd[0] | rnd[2];
    wr_valid = wq.size() > 0;
    wr_data  = wr_valid ? wq[0] : rnd;
  end
  always @(posedge sys_clk) begin
    if (wr_ready === 1'b1 && wq.size() > 0) void'(wq.pop_front());
    if (m_en === 1'b1 && mem_io_oe === 1'b1) chk("io clash", 16'h0000, 16'h0001);
    if (rd_valid === 1'b1 && rd_ready) begin
      if (rq.size() == 0) chk("extra rd_valid", 16'h0000, 16'h0001);
      else chk("rd_data", rq.pop_front(), rd_data);
    end
  end
  initial begin
    {reset_n, cmd_valid, cmd_kind, cmd_addr, cmd_len, rnd, wp_n} = {26'h0, 8'h0c, 1'b1};
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1;
    chk("cmd_ready", 16'h0001, 16'(cmd_ready));
    chk("busy", 16'h0000, 16'(busy));
    run(bsp_pkg::BSP_CMD_READ, 16'hfffe, 4);
    run(bsp_pkg::BSP_CMD_WRITE, 16'h005e, 4);
    chk("nv_busy", 16'h0001, 16'(nv_busy));
    run(bsp_pkg::BSP_CMD_POLL, 16'h0, 0);
    chk("poll busy", 16'h0001, 16'(nv_busy));
    for (int p = 0; p < 30 && nv_busy === 1'b1; p++) run(bsp_pkg::BSP_CMD_POLL, 16'h0, 0);
    chk("poll done", 16'h0000, 16'(nv_busy));
    run(bsp_pkg::BSP_CMD_READ, 16'h0040, 32);
    wp_n = 0;
    run(bsp_pkg::BSP_CMD_WRITE, 16'h0100, 2);
    run(bsp_pkg::BSP_CMD_POLL, 16'h0, 0);
    chk("nv_busy", 16'h0000, 16'(nv_busy));
    run(bsp_pkg::BSP_CMD_READ, 16'h0100, 2);
    summarize();
  end
endmodule
